// >>> rtl/rcad_cfg.svh
// Purpose: Constants of the RC counting converter register block.
// Assumes: Classic Wishbone, 32-bit data, word index is wb_adr_i[7:2].
// Notes:   Functional notes follow.
// Functional notes
// - Counter A bits 4-7, 8-11, 12-15 are three 4-bit read/write registers.
// - Counter A bits 16-18 sit in bits 0-2; bit 3 reserved.
// - Counter B bits 4-7 and 8-11 are two 4-bit read/write registers.
// - Counter B bits 12-13 sit in bits 0-1; bits 2-3 reserved.
// - Reserved counter bits read as one; writes to them do nothing.
// - A control bit picks counter A or counter B overflow as interrupt.
// - A control bit runs or halts the RC oscillation feeding the counters.
// - A second control register selects the oscillation or external clock mode.
// - Software can read and write counters A and B through nibble registers.
// - Source select bit: 0 counter A overflow (reset), 1 counter B overflow.
// - Run bit: 0 oscillation stopped (reset), 1 oscillation started.
// - Mode 0 pin one clock, 1 to 6 RC pairings, 7 pin two clock.
`ifndef RCAD_CFG_SVH
`define RCAD_CFG_SVH

// Bus geometry.
`define RCAD_ADR_W      8
`define RCAD_DAT_W      32
`define RCAD_IDX_W      6
`define RCAD_NIB_W      4

// Word indices; the byte address is four times the index.
`define RCAD_IDX_CNT_A0 6'h20
`define RCAD_IDX_CNT_A1 6'h21
`define RCAD_IDX_CNT_A2 6'h22
`define RCAD_IDX_CNT_A3 6'h23
`define RCAD_IDX_CNT_A4 6'h24
`define RCAD_IDX_CNT_B0 6'h26
`define RCAD_IDX_CNT_B1 6'h27
`define RCAD_IDX_CNT_B2 6'h28
`define RCAD_IDX_CNT_B3 6'h29
`define RCAD_IDX_CTRL   6'h2a
`define RCAD_IDX_OSC    6'h2b
`define RCAD_IDX_STAT   6'h2c
`define RCAD_IDX_MASK   6'h2d

// Counter widths and nibble index width.
`define RCAD_CNT_A_W    19
`define RCAD_CNT_B_W    14
`define RCAD_NIDX_W     3

// Reserved bits that read as one.
`define RCAD_RSV_A4     4'h8
`define RCAD_RSV_B3     4'hc
`define RCAD_RSV_CTRL   4'hc

// Control bit positions and reset values.
`define RCAD_CTRL_RUN   0
`define RCAD_CTRL_SRC   1
`define RCAD_RUN_RST    1'b0
`define RCAD_SRC_RST    1'b0
`define RCAD_OSC_RST    4'h0

// Interrupt status bits.
`define RCAD_IRQ_W      3
`define RCAD_IRQ_AD     0
`define RCAD_IRQ_OVF_A  1
`define RCAD_IRQ_OVF_B  2

// Clock sources: index 0 first pin, 1..6 RC pairings, 7 second pin.
`define RCAD_RC_PAIRS   6
`define RCAD_NSRC       8
`define RCAD_SYNC_N     9
`define RCAD_TBASE_IDX  8

`endif

// >>> rtl/rcad_pkg.sv
// Purpose: Types of the RC counting converter register block.
// Assumes: Constants come from rcad_cfg.svh.
// Notes:   Holds enumerations only.
package rcad_pkg;

    // Oscillation and external clock modes.
    typedef enum logic [3:0] {
        RCAD_OSC_EXT_FIRST  = 4'b0000,
        RCAD_OSC_PAIR_1     = 4'b0001,
        RCAD_OSC_PAIR_2     = 4'b0010,
        RCAD_OSC_PAIR_3     = 4'b0011,
        RCAD_OSC_PAIR_4     = 4'b0100,
        RCAD_OSC_PAIR_5     = 4'b0101,
        RCAD_OSC_PAIR_6     = 4'b0110,
        RCAD_OSC_EXT_SECOND = 4'b0111
    } rcad_osc_mode_t;

    // Bus slave states.
    typedef enum logic {
        RCAD_BUS_IDLE = 1'b0,
        RCAD_BUS_ACK  = 1'b1
    } rcad_bus_state_t;

endpackage : rcad_pkg

// >>> rtl/rcad_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk_sys.
// Notes:   Level changes only once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module rcad_sync (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic srst,
    // Pin side.
    input  wire logic pin_in,
    // Filtered outputs.
    output logic      level,
    output logic      rise
);
    import rcad_pkg::*;

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic lvl_reg;
    logic rise_reg;
    wire  agree = (s2_reg == s3_reg);

    // Stage one feeds only stage two; the filtered level follows agreement.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s1_reg   <= 1'b0;
            s2_reg   <= 1'b0;
            s3_reg   <= 1'b0;
            lvl_reg  <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            s1_reg   <= pin_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            lvl_reg  <= agree ? s3_reg : lvl_reg;
            rise_reg <= agree & s3_reg & ~lvl_reg;
        end
    end

    assign level = lvl_reg;
    assign rise  = rise_reg;
endmodule : rcad_sync
`default_nettype wire

// >>> rtl/rcad_counter.sv
// Purpose: Binary counter with nibble-wide software writes.
// Assumes: Nibble index is within the counter's width.
// Notes:   A write in the same cycle as a count wins and drops that count.
`timescale 1ns/100ps
`default_nettype none
`include "rcad_cfg.svh"
module rcad_counter #(
    parameter int WIDTH = `RCAD_CNT_A_W
) (
    // Clock and reset.
    input  wire logic                     clk_sys,
    input  wire logic                     srst,
    // Count request.
    input  wire logic                     inc,
    // Nibble write.
    input  wire logic                     wr_en,
    input  wire logic [`RCAD_NIDX_W-1:0]  wr_idx,
    input  wire logic [`RCAD_NIB_W-1:0]   wr_data,
    // State.
    output logic      [WIDTH-1:0]         count,
    output logic                          ovf
);
    import rcad_pkg::*;

    localparam int NP = (WIDTH + `RCAD_NIB_W - 1) / `RCAD_NIB_W;

    logic [WIDTH-1:0]           count_reg;
    logic                       ovf_reg;
    logic [NP*`RCAD_NIB_W-1:0]  merged;

    // Replace only the addressed nibble; bits above the width are dropped.
    always_comb begin
        merged = '0;
        merged[WIDTH-1:0] = count_reg;
        merged[wr_idx*`RCAD_NIB_W +: `RCAD_NIB_W] = wr_data;
    end

    // Count wraps to zero and flags the overflow for one cycle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count_reg <= '0;
            ovf_reg   <= 1'b0;
        end else if (wr_en) begin
            count_reg <= merged[WIDTH-1:0];
            ovf_reg   <= 1'b0;
        end else begin
            count_reg <= inc ? count_reg + 1'b1 : count_reg;
            ovf_reg   <= inc & (&count_reg);
        end
    end

    assign count = count_reg;
    assign ovf   = ovf_reg;
endmodule : rcad_counter
`default_nettype wire

// >>> rtl/rcad_top.sv
// Purpose: Register block of the RC oscillation counting converter.
// Assumes: Classic Wishbone master; pins are asynchronous to clk_sys.
// Notes:   Counter A counts the selected oscillator, counter B a time base.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "rcad_cfg.svh"
module rcad_top (
    // Clock and reset.
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    // Wishbone slave.
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [`RCAD_ADR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [`RCAD_DAT_W-1:0]      wb_dat_i,
    output logic      [`RCAD_DAT_W-1:0]      wb_dat_o,
    output logic                             wb_ack_o,
    // Clock source pins.
    input  wire logic                        ext_clock_pin_first,
    input  wire logic                        ext_clock_pin_second,
    input  wire logic [`RCAD_RC_PAIRS-1:0]   rc_osc_in,
    input  wire logic                        tbase_in,
    // Oscillator control and interrupt.
    output logic      [`RCAD_RC_PAIRS-1:0]   rc_osc_en,
    output logic                             irq
);
    import rcad_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************

    rcad_bus_state_t               bus_state_reg;
    rcad_bus_state_t               bus_state_next;
    logic [`RCAD_DAT_W-1:0]        dat_reg;
    logic                          conversion_run_reg;
    logic                          irq_source_select_reg;
    rcad_osc_mode_t                osc_mode_reg;
    logic [`RCAD_IRQ_W-1:0]        stat_reg;
    logic [`RCAD_IRQ_W-1:0]        stat_next;
    logic [`RCAD_IRQ_W-1:0]        mask_reg;
    logic                          irq_reg;
    logic [`RCAD_RC_PAIRS-1:0]     osc_en_reg;
    logic [`RCAD_CNT_A_W-1:0]      count_a;
    logic [`RCAD_CNT_B_W-1:0]      count_b;
    logic                          ovf_a;
    logic                          ovf_b;
    logic [`RCAD_SYNC_N-1:0]       sync_in;
    logic [`RCAD_SYNC_N-1:0]       src_rise;

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Maps a mode code to a one-hot RC pairing enable; external modes give none.
    function automatic logic [`RCAD_RC_PAIRS-1:0] pair_enable(input rcad_osc_mode_t m);
        logic [`RCAD_RC_PAIRS-1:0] en;
        en = '0;
        case (m)
            RCAD_OSC_PAIR_1: en[0] = 1'b1;
            RCAD_OSC_PAIR_2: en[1] = 1'b1;
            RCAD_OSC_PAIR_3: en[2] = 1'b1;
            RCAD_OSC_PAIR_4: en[3] = 1'b1;
            RCAD_OSC_PAIR_5: en[4] = 1'b1;
            RCAD_OSC_PAIR_6: en[5] = 1'b1;
            default:         en = '0;
        endcase
        return en;
    endfunction : pair_enable

    // True when a word index falls inside a counter's nibble window.
    function automatic logic in_window(input logic [`RCAD_IDX_W-1:0] idx,
                                       input logic [`RCAD_IDX_W-1:0] lo,
                                       input logic [`RCAD_IDX_W-1:0] hi);
        return (idx >= lo) && (idx <= hi);
    endfunction : in_window

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************

    // Gather the source pins; the time base sits above the eight sources.
    assign sync_in = {tbase_in, ext_clock_pin_second, rc_osc_in, ext_clock_pin_first};

    // One three-stage synchroniser per source pin.
    genvar gi;
    generate
        for (gi = 0; gi < `RCAD_SYNC_N; gi = gi + 1) begin : g_sync
            rcad_sync u_sync (
                .clk_sys (clk_sys),
                .srst    (srst),
                .pin_in  (sync_in[gi]),
                .level   (),
                .rise    (src_rise[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    // Request decode; the access is taken in the cycle before ack rises.
    wire                    req      = wb_cyc_i & wb_stb_i & (bus_state_reg == RCAD_BUS_IDLE);
    wire                    wr_stb   = req & wb_we_i & wb_sel_i[0];
    wire [`RCAD_IDX_W-1:0]  idx      = wb_adr_i[`RCAD_ADR_W-1:2];
    wire [`RCAD_NIB_W-1:0]  wnib     = wb_dat_i[`RCAD_NIB_W-1:0];
    wire                    hit_a    = in_window(idx, `RCAD_IDX_CNT_A0, `RCAD_IDX_CNT_A4);
    wire                    hit_b    = in_window(idx, `RCAD_IDX_CNT_B0, `RCAD_IDX_CNT_B3);
    wire                    wr_a     = wr_stb & hit_a;
    wire                    wr_b     = wr_stb & hit_b;
    wire                    wr_ctrl  = wr_stb & (idx == `RCAD_IDX_CTRL);
    wire                    wr_osc   = wr_stb & (idx == `RCAD_IDX_OSC);
    wire                    wr_stat  = wr_stb & (idx == `RCAD_IDX_STAT);
    wire                    wr_mask  = wr_stb & (idx == `RCAD_IDX_MASK);
    wire [`RCAD_IDX_W-1:0]  off_a    = idx - `RCAD_IDX_CNT_A0;
    wire [`RCAD_IDX_W-1:0]  off_b    = idx - `RCAD_IDX_CNT_B0;
    wire [`RCAD_NIDX_W-1:0] nidx_a   = off_a[`RCAD_NIDX_W-1:0];
    wire [`RCAD_NIDX_W-1:0] nidx_b   = off_b[`RCAD_NIDX_W-1:0];

    // Read mux; reserved bits are forced to one and unmapped words read zero.
    logic [`RCAD_NIB_W-1:0] rd_nib;
    always_comb begin
        case (idx)
            `RCAD_IDX_CNT_A0: rd_nib = count_a[3:0];
            `RCAD_IDX_CNT_A1: rd_nib = count_a[7:4];
            `RCAD_IDX_CNT_A2: rd_nib = count_a[11:8];
            `RCAD_IDX_CNT_A3: rd_nib = count_a[15:12];
            `RCAD_IDX_CNT_A4: rd_nib = `RCAD_RSV_A4 | {1'b0, count_a[18:16]};
            `RCAD_IDX_CNT_B0: rd_nib = count_b[3:0];
            `RCAD_IDX_CNT_B1: rd_nib = count_b[7:4];
            `RCAD_IDX_CNT_B2: rd_nib = count_b[11:8];
            `RCAD_IDX_CNT_B3: rd_nib = `RCAD_RSV_B3 | {2'b00, count_b[13:12]};
            `RCAD_IDX_CTRL:   rd_nib = `RCAD_RSV_CTRL |
                                       {2'b00, irq_source_select_reg, conversion_run_reg};
            `RCAD_IDX_OSC:    rd_nib = osc_mode_reg;
            `RCAD_IDX_STAT:   rd_nib = {1'b0, stat_reg};
            `RCAD_IDX_MASK:   rd_nib = {1'b0, mask_reg};
            default:          rd_nib = 4'h0;
        endcase
    end

    // Two-state answer: ack one cycle after the request, then release.
    always_comb begin
        case (bus_state_reg)
            RCAD_BUS_IDLE: bus_state_next = (wb_cyc_i & wb_stb_i) ? RCAD_BUS_ACK : RCAD_BUS_IDLE;
            RCAD_BUS_ACK:  bus_state_next = RCAD_BUS_IDLE;
            default:       bus_state_next = RCAD_BUS_IDLE;
        endcase
    end

    // Bus answer registers.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_state_reg <= RCAD_BUS_IDLE;
            dat_reg       <= '0;
        end else begin
            bus_state_reg <= bus_state_next;
            dat_reg       <= req ? {{(`RCAD_DAT_W-`RCAD_NIB_W){1'b0}}, rd_nib} : dat_reg;
        end
    end

    assign wb_ack_o = (bus_state_reg == RCAD_BUS_ACK);
    assign wb_dat_o = dat_reg;

    // ****************************************************************
    // Control registers
    // ****************************************************************

    // Run and source select bits; reserved bits are not stored.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            conversion_run_reg    <= `RCAD_RUN_RST;
            irq_source_select_reg <= `RCAD_SRC_RST;
        end else if (wr_ctrl) begin
            conversion_run_reg    <= wnib[`RCAD_CTRL_RUN];
            irq_source_select_reg <= wnib[`RCAD_CTRL_SRC];
        end
    end

    // Oscillation mode field, full four bits stored.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            osc_mode_reg <= rcad_osc_mode_t'(`RCAD_OSC_RST);
        end else if (wr_osc) begin
            osc_mode_reg <= rcad_osc_mode_t'(wnib);
        end
    end

    // Drive the chosen RC pairing only while conversion runs.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            osc_en_reg <= '0;
        end else begin
            osc_en_reg <= conversion_run_reg ? pair_enable(osc_mode_reg) : '0;
        end
    end

    assign rc_osc_en = osc_en_reg;

    // ****************************************************************
    // Counters
    // ****************************************************************

    // Selected source edge; codes above seven pick no source.
    wire sel_rise = (osc_mode_reg <= RCAD_OSC_EXT_SECOND) &
                    src_rise[osc_mode_reg[`RCAD_NIDX_W-1:0]];
    wire inc_a    = conversion_run_reg & sel_rise;
    wire inc_b    = conversion_run_reg & src_rise[`RCAD_TBASE_IDX];

    rcad_counter #(.WIDTH(`RCAD_CNT_A_W)) u_count_a (
        .clk_sys (clk_sys),
        .srst    (srst),
        .inc     (inc_a),
        .wr_en   (wr_a),
        .wr_idx  (nidx_a),
        .wr_data (wnib),
        .count   (count_a),
        .ovf     (ovf_a)
    );

    rcad_counter #(.WIDTH(`RCAD_CNT_B_W)) u_count_b (
        .clk_sys (clk_sys),
        .srst    (srst),
        .inc     (inc_b),
        .wr_en   (wr_b),
        .wr_idx  (nidx_b),
        .wr_data (wnib),
        .count   (count_b),
        .ovf     (ovf_b)
    );

    // ****************************************************************
    // Interrupts
    // ****************************************************************

    // Sticky events; a new event wins over a write-one clear.
    wire [`RCAD_IRQ_W-1:0] ev;
    assign ev[`RCAD_IRQ_AD]    = irq_source_select_reg ? ovf_b : ovf_a;
    assign ev[`RCAD_IRQ_OVF_A] = ovf_a;
    assign ev[`RCAD_IRQ_OVF_B] = ovf_b;
    assign stat_next = (stat_reg & ~(wr_stat ? wnib[`RCAD_IRQ_W-1:0] : '0)) | ev;

    // Status, mask and the level interrupt output.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stat_reg <= '0;
            mask_reg <= '0;
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            mask_reg <= wr_mask ? wnib[`RCAD_IRQ_W-1:0] : mask_reg;
            irq_reg  <= |(stat_reg & mask_reg);
        end
    end

    assign irq = irq_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_read_a4;
        req & ~wb_we_i & (idx == `RCAD_IDX_CNT_A4);
    endsequence

    sequence s_wr_a1;
        wr_a & (idx == `RCAD_IDX_CNT_A1) & ~inc_a;
    endsequence

    ack_single_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    ack_follows_req_a: assert property (wb_cyc_i & wb_stb_i & !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    rsv_reads_one_a: assert property (s_read_a4 |=> wb_ack_o && wb_dat_o[3])
        else $error("reserved bit of top nibble did not read one");
    nib_write_only_a: assert property (s_wr_a1 |=> count_a[7:4] == $past(wnib) &&
            count_a[3:0] == $past(count_a[3:0]) && count_a[18:8] == $past(count_a[18:8]))
        else $error("nibble write disturbed other counter bits");
    stopped_no_count_a: assert property (!conversion_run_reg && !wr_a |=> $stable(count_a))
        else $error("counter A moved while conversion stopped");
    irq_source_a_a: assert property (ovf_a && !irq_source_select_reg |=> stat_reg[`RCAD_IRQ_AD])
        else $error("counter A overflow did not raise request");
    irq_source_b_a: assert property (ovf_b && irq_source_select_reg |=> stat_reg[`RCAD_IRQ_AD])
        else $error("counter B overflow did not raise request");
    osc_pair_one_a: assert property (conversion_run_reg && osc_mode_reg == RCAD_OSC_PAIR_1 &&
            !wr_ctrl && !wr_osc |=> ##1 rc_osc_en == 6'h01)
        else $error("first RC pairing not enabled");
    irq_level_a: assert property (|(stat_reg & mask_reg) |=> irq)
        else $error("interrupt output low with unmasked status");

    // Low nibble of the read data as the master takes it.
    wire [`RCAD_NIB_W-1:0] q_nib = wb_dat_o[`RCAD_NIB_W-1:0];

    sequence s_read_b3;
        req & ~wb_we_i & (idx == `RCAD_IDX_CNT_B3);
    endsequence

    sequence s_read_a1;
        req & ~wb_we_i & (idx == `RCAD_IDX_CNT_A1);
    endsequence

    sequence s_read_b1;
        req & ~wb_we_i & (idx == `RCAD_IDX_CNT_B1);
    endsequence

    // A read shows the addressed nibble with ack; upper bits stay clear.
    read_a1_a: assert property (s_read_a1 |=> q_nib == $past(count_a[7:4]))
        else $error("counter A nibble one read wrong");
    read_b1_a: assert property (s_read_b1 |=> q_nib == $past(count_b[7:4]))
        else $error("counter B nibble one read wrong");
    rsv_b3_one_a: assert property (s_read_b3 |=> (q_nib & `RCAD_RSV_B3) == `RCAD_RSV_B3)
        else $error("reserved bits of counter B top read zero");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[`RCAD_DAT_W-1:`RCAD_NIB_W] == '0)
        else $error("read data above the nibble not zero");

    // Control writes land whole; a stopped converter holds still.
    ctrl_write_a: assert property (wr_ctrl |=>
            conversion_run_reg == $past(wnib[`RCAD_CTRL_RUN]) &&
            irq_source_select_reg == $past(wnib[`RCAD_CTRL_SRC]))
        else $error("control write not stored");
    osc_write_a: assert property (wr_osc |=> osc_mode_reg == $past(wnib))
        else $error("mode write not stored");
    run_stop_a: assert property (!conversion_run_reg |=> rc_osc_en == '0)
        else $error("RC pairing enabled while stopped");
    stopped_b_a: assert property (!conversion_run_reg && !wr_b |=> $stable(count_b))
        else $error("counter B moved while stopped");
    mode_none_a: assert property (osc_mode_reg > RCAD_OSC_EXT_SECOND |-> !inc_a)
        else $error("counter A counted with no source");

    // Write-one clear, wrap to zero and a quiet interrupt output.
    stat_clear_a: assert property (wr_stat && wnib[`RCAD_IRQ_AD] && !ev[`RCAD_IRQ_AD] |=>
            !stat_reg[`RCAD_IRQ_AD])
        else $error("request flag not cleared");
    ovf_wrap_a: assert property (ovf_a |-> count_a == '0)
        else $error("counter A overflow without wrap");
    irq_low_a: assert property (!(|(stat_reg & mask_reg)) |=> !irq)
        else $error("interrupt output high with nothing unmasked");

endmodule : rcad_top
`default_nettype wire

// >>> verification/rcad_osc_model.sv
// Purpose: Far-side model of the converter's clock sources.
// Assumes: One toggle period of sixteen system clocks suits every source.
// Notes:   Pairing oscillators run only while the block enables them.
`timescale 1ns/100ps
`default_nettype none
module rcad_osc_model (
    // Clock and bench gate.
    input  wire logic       clk_sys,
    input  wire logic       pins_on,
    // Oscillator enables from the block.
    input  wire logic [5:0] rc_osc_en,
    // Source outputs.
    output logic            ext_clock_pin_first,
    output logic            ext_clock_pin_second,
    output logic [5:0]      rc_osc_in,
    output logic            tbase_in
);
    logic [3:0] div_reg = 4'h0;
    // Free divider that sets the oscillation period.
    always_ff @(posedge clk_sys) begin
        div_reg <= div_reg + 4'h1;
    end
    // Stopped sources idle low, as an unpowered oscillator does.
    assign ext_clock_pin_first  = pins_on & div_reg[3];
    assign ext_clock_pin_second = pins_on & div_reg[3];
    assign tbase_in             = pins_on & div_reg[3];
    assign rc_osc_in            = rc_osc_en & {6{div_reg[3]}};
endmodule : rcad_osc_model
`default_nettype wire

// >>> verification/rcad_top_tb.sv
// Purpose: Self-checking bench of the converter register block.
// Assumes: Classic Wishbone single cycles; one idle cycle between them.
// Notes:   Counters are stopped while their nibbles are compared.
`timescale 1ns/100ps
`default_nettype none
`include "rcad_cfg.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module rcad_top_tb;
    logic        clk_sys, srst, cyc, stb, we, pins_on, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r;
    logic        pin_a, pin_b, tbase;
    logic [5:0]  rc_in, rc_en;
    int          mismatches = 0;
    int          cmp_count = 0;
    // Design and far-side model.
    rcad_top i_rcad_top (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .ext_clock_pin_first(pin_a), .ext_clock_pin_second(pin_b),
        .rc_osc_in(rc_in), .tbase_in(tbase), .rc_osc_en(rc_en), .irq(irq));
    rcad_osc_model i_rcad_osc_model (.clk_sys(clk_sys), .pins_on(pins_on), .rc_osc_en(rc_en),
        .ext_clock_pin_first(pin_a), .ext_clock_pin_second(pin_b), .rc_osc_in(rc_in),
        .tbase_in(tbase));
    // One bus cycle, held until ack is sampled high.
    task automatic bus(input logic w, input logic [5:0] idx, input logic [3:0] d,
                       input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00};
        dat_w <= {28'h0, d}; sel <= s;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_r;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 50) mismatches++;
    endtask : bus
    task automatic wr(input logic [5:0] idx, input logic [3:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, 4'hf, q);
    endtask : wr
    task automatic rd(input logic [5:0] idx, input logic [3:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 4'h0, 4'hf, q);
        `CHK(q, {28'h0, e})
    endtask : rd
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(irq, 1'b1)
    endtask : wait_irq
    // Reset values, reserved bits reading one.
    task automatic t_reset;
        rd(`RCAD_IDX_CNT_A4, 4'h8);
        rd(`RCAD_IDX_CNT_B3, 4'hc);
        rd(`RCAD_IDX_CTRL, 4'hc);
        rd(`RCAD_IDX_OSC, 4'h0);
        rd(`RCAD_IDX_CNT_A1, 4'h0);
        $display("test reset done");
    endtask : t_reset
    // Nibble placement, partial writes, ignored writes.
    task automatic t_nibbles;
        logic [31:0] q;
        for (int i = 0; i < 5; i++) wr(6'(`RCAD_IDX_CNT_A0 + i), 4'(i + 1));
        for (int i = 0; i < 4; i++) wr(6'(`RCAD_IDX_CNT_B0 + i), 4'(i + 6));
        wr(`RCAD_IDX_CNT_A2, 4'ha);
        bus(1'b1, `RCAD_IDX_CNT_A0, 4'h0, 4'h0, q);
        rd(`RCAD_IDX_CNT_A0, 4'h1);
        rd(`RCAD_IDX_CNT_A1, 4'h2);
        rd(`RCAD_IDX_CNT_A2, 4'ha);
        rd(`RCAD_IDX_CNT_A3, 4'h4);
        rd(`RCAD_IDX_CNT_A4, 4'hd);
        rd(`RCAD_IDX_CNT_B1, 4'h7);
        rd(`RCAD_IDX_CNT_B2, 4'h8);
        rd(`RCAD_IDX_CNT_B3, 4'hd);
        rd(6'h3f, 4'h0);
        $display("test nibbles done");
    endtask : t_nibbles
    // Every oscillation mode, with run on and then off.
    task automatic t_modes;
        for (int m = 0; m < 9; m++) begin
            wr(`RCAD_IDX_OSC, 4'(m));
            wr(`RCAD_IDX_CTRL, 4'h1);
            repeat (2) @(posedge clk_sys);
            `CHK(rc_en, (m >= 1 && m <= 6) ? 6'(1 << (m - 1)) : 6'h0)
            wr(`RCAD_IDX_CTRL, 4'h0);
            repeat (2) @(posedge clk_sys);
            `CHK(rc_en, 6'h0)
        end
        $display("test modes done");
    endtask : t_modes
    // Overflow of the selected counter, masking and clearing.
    task automatic t_irq;
        for (int i = 0; i < 4; i++) wr(6'(`RCAD_IDX_CNT_A0 + i), 4'hf);
        wr(`RCAD_IDX_CNT_A4, 4'h7);
        wr(`RCAD_IDX_OSC, 4'h0);
        wr(`RCAD_IDX_MASK, 4'h1);
        pins_on <= 1'b1;
        wr(`RCAD_IDX_CTRL, 4'h1);
        wait_irq();
        rd(`RCAD_IDX_STAT, 4'h3);
        wr(`RCAD_IDX_MASK, 4'h0);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        wr(`RCAD_IDX_CTRL, 4'h0);
        wr(`RCAD_IDX_STAT, 4'h7);
        rd(`RCAD_IDX_STAT, 4'h0);
        for (int i = 0; i < 3; i++) wr(6'(`RCAD_IDX_CNT_B0 + i), 4'hf);
        wr(`RCAD_IDX_CNT_B3, 4'h3);
        wr(`RCAD_IDX_MASK, 4'h1);
        wr(`RCAD_IDX_CTRL, 4'h3);
        wait_irq();
        rd(`RCAD_IDX_STAT, 4'h5);
        wr(`RCAD_IDX_CTRL, 4'h0);
        pins_on <= 1'b0;
        $display("test irq done");
    endtask : t_irq
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // Clock generation.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Watchdog against a hung bus or a missing interrupt.
    initial begin
        #400000;
        mismatches++;
        test_done();
    end
    // Main sequence.
    initial begin
        srst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        sel = 4'h0; dat_w = 32'h0; pins_on = 1'b0;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_nibbles();
        t_modes();
        t_irq();
        test_done();
    end
endmodule : rcad_top_tb
`default_nettype wire
